//--- hdl/serial_ir_status_mode_control.sv
// mode control, line status, modem status and scratch registers of a serial/infrared port,
// with a bit-level receiver, receive and transmit queues and the dma data path
// assumes bit_tick pulses once per bit at mid-bit, and all inputs are synchronous to clk
// How it works
// - dma reaches data queues only while dma enable bit 2 is set, any bank
// - deferral default off, needs transmit fifo
// - bits 7-5 select uart, ask, sir, consumer
// - mode change flushes queues, clears status
// - line status resets 60h, read clears
// - error bits 4..1 raise line interrupt
// - data-available while any character is held
// - overrun drops new character, keeps stored
// - parity error travels, shows at head
// - zero stop bit flags framing error
// - after framing error, zero bit starts
// - zero run of character flags break
// - one zero character per break, then wait
// - transmit ready when holding queue empty
// - transmitter idle needs empty queue, shifter
// - queued error summary, zero without fifo
// - ir with select set reads 30h
// - loopback feeds status from control bits
// - delta bits raise event, clear on read, or on mode change with select clear
// - deltas on change, ring on falling
// - bits 7..4 are inverted modem inputs
// - extended loopback dtr drives dsr, ring
`timescale 1ns/1ps
`include "serial_ir_status_map.svh"

module serial_ir_status_mode_control
  import serial_ir_status_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       extended_mode,
  input  wire logic       fifo_enable,
  input  wire logic       loop_ext,
  input  wire logic       ir_msr_select,
  input  wire logic       parity_enable,
  input  wire logic       parity_even,
  input  wire logic       line_irq_enable,
  input  wire logic       modem_status_irq_enable,
  input  wire logic       rx_soft_reset,
  input  wire logic       tx_soft_reset,
  input  wire logic       rx_line,
  input  wire logic       bit_tick,
  input  wire logic       dma_rd,
  input  wire logic       dma_wr,
  input  wire logic [7:0] dma_wdata,
  output logic      [7:0] dma_rdata,
  output logic            dma_enable,
  input  wire logic       tx_take,
  input  wire logic       tx_shifter_busy,
  output logic      [7:0] tx_data,
  output logic            tx_avail,
  output logic            transmit_deferral,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       dcd_n,
  output logic            dtr_n,
  output logic            rts_n,
  output logic      [2:0] operating_mode_field,
  output logic            aux_status_clear,
  output logic            line_status_irq,
  output logic            modem_status_event
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [7:0]                modem_mode_control_ext;
    logic [7:0]                scratch_byte;
    logic                      oe;
    logic                      pe;
    logic                      fe;
    logic                      line_break_flag;
    logic                      head_seen;
    rx_entry_s [DEPTH-1:0]     rxm;
    logic [AW-1:0]             rx_rd;
    logic [AW-1:0]             rx_wr;
    logic [CW-1:0]             rx_cnt;
    logic [DEPTH-1:0][7:0]     txm;
    logic [AW-1:0]             tx_rd;
    logic [AW-1:0]             tx_wr;
    logic [CW-1:0]             tx_cnt;
    modem_lines_s              prev;
    logic [3:0]                delta;
    rx_state_e                 rxs;
    logic [2:0]                bitn;
    logic [7:0]                sh;
    logic                      pbit;
    logic [7:0]                rdata;
    logic [7:0]                dmard;
    logic                      aux_clr;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic [2:0]   mode;
  logic         consumer;
  logic         ir_mode;
  logic         loop_on;
  modem_lines_s lvl;
  logic [CW-1:0] cap;
  logic         mode_change;
  logic         rx_push;
  logic         rx_pop;
  logic         tx_push;
  logic         tx_pop;
  logic [7:0]   tx_byte;
  rx_entry_s    new_entry;
  rx_entry_s    head;
  logic         any_queued_err;
  logic         lsr_read;
  logic         msr_read;
  logic [7:0]   lsr_val;
  logic [7:0]   msr_val;

  assign mode     = extended_mode ? st_r.modem_mode_control_ext[`SIS_MCR_MODE_HI:`SIS_MCR_MODE_LO] : `SIS_MODE_UART;
  assign consumer = (mode == `SIS_MODE_CONSUMER);
  assign ir_mode  = (mode == `SIS_MODE_ASK_IR) || (mode == `SIS_MODE_SIR) || consumer;
  assign loop_on  = extended_mode ? loop_ext : st_r.modem_mode_control_ext[`SIS_MCR_LOOP];
  assign head     = st_r.rxm[st_r.rx_rd];
  assign cap      = fifo_enable ? CW'(DEPTH) : CW'(1);

  // modem status sources: pins normally, control bits in loopback
  always_comb begin
    lvl = '{dcd: ~dcd_n, ri: ~ri_n, dsr: ~dsr_n, cts: ~cts_n};
    if (loop_on && extended_mode) begin
      lvl.dsr = st_r.modem_mode_control_ext[`SIS_MCR_DTR];
      lvl.ri  = st_r.modem_mode_control_ext[`SIS_MCR_DTR];
      lvl.cts = st_r.modem_mode_control_ext[`SIS_MCR_RTS];
      lvl.dcd = st_r.modem_mode_control_ext[`SIS_MCR_RTS];
    end else if (loop_on) begin
      lvl.dsr = st_r.modem_mode_control_ext[`SIS_MCR_DTR];
      lvl.cts = st_r.modem_mode_control_ext[`SIS_MCR_RTS];
      lvl.ri  = st_r.modem_mode_control_ext[2];
      lvl.dcd = st_r.modem_mode_control_ext[3];
    end
  end

  always_comb begin
    any_queued_err = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (CW'(i) < st_r.rx_cnt) begin
        any_queued_err = any_queued_err | (st_r.rxm[AW'(st_r.rx_rd + AW'(i))].pe
                                         | st_r.rxm[AW'(st_r.rx_rd + AW'(i))].fe
                                         | st_r.rxm[AW'(st_r.rx_rd + AW'(i))].line_break_flag);
      end
    end
  end

  assign lsr_val = {fifo_enable & ~consumer & any_queued_err,
                    (st_r.tx_cnt == '0) & ~tx_shifter_busy,
                    (st_r.tx_cnt == '0),
                    st_r.line_break_flag, st_r.fe, st_r.pe, st_r.oe,
                    (st_r.rx_cnt != '0)};

  assign msr_val = (ir_mode && ir_msr_select) ? `SIS_MSR_IR_FIXED : {lvl, st_r.delta};

  assign lsr_read    = reg_rd && (reg_addr == `SIS_OFF_LINE_STAT);
  assign msr_read    = reg_rd && (reg_addr == `SIS_OFF_MODEM_STAT) && !(ir_mode && ir_msr_select);
  assign mode_change = reg_wr && extended_mode && (reg_addr == `SIS_OFF_MODE_CTRL)
                       && (reg_wdata[`SIS_MCR_MODE_HI:`SIS_MCR_MODE_LO]
                           != st_r.modem_mode_control_ext[`SIS_MCR_MODE_HI:`SIS_MCR_MODE_LO]);

  // data port: host at offset 0, or dma regardless of any bank selection
  assign rx_pop  = (st_r.rx_cnt != '0) && ((reg_rd && reg_addr == `SIS_OFF_DATA)
                   || (dma_rd && st_r.modem_mode_control_ext[`SIS_MCR_DMA_EN]));
  assign tx_push = (st_r.tx_cnt < cap) && ((reg_wr && reg_addr == `SIS_OFF_DATA)
                   || (dma_wr && st_r.modem_mode_control_ext[`SIS_MCR_DMA_EN]));
  assign tx_byte = (reg_wr && reg_addr == `SIS_OFF_DATA) ? reg_wdata : dma_wdata;
  assign tx_pop  = tx_take && (st_r.tx_cnt != '0);

  always_comb begin
    st_nxt    = st_r;
    rx_push   = 1'b0;
    new_entry = '0;
    st_nxt.aux_clr = mode_change;

    // bit-level receiver
    if (bit_tick) begin
      case (st_r.rxs)
        RX_IDLE: begin
          if (!rx_line) begin
            st_nxt.rxs  = RX_DATA;
            st_nxt.bitn = '0;
          end
        end
        RX_DATA: begin
          st_nxt.sh   = {rx_line, st_r.sh[7:1]};
          st_nxt.bitn = st_r.bitn + 3'h1;
          if (st_r.bitn == 3'h7) begin
            st_nxt.rxs  = parity_enable ? RX_PARITY : RX_STOP;
            st_nxt.pbit = 1'b0;
          end
        end
        RX_PARITY: begin
          st_nxt.pbit = rx_line;
          st_nxt.rxs  = RX_STOP;
        end
        RX_STOP: begin
          rx_push        = 1'b1;
          new_entry.data = st_r.sh;
          new_entry.pe   = parity_enable && ((^st_r.sh ^ st_r.pbit) == parity_even) && !consumer;
          new_entry.fe   = !rx_line && !consumer;
          if (!rx_line && st_r.sh == 8'h00 && !st_r.pbit) begin
            new_entry.line_break_flag = !consumer;
            new_entry.pe  = 1'b0;
            st_nxt.rxs    = RX_HOLD;
          end else begin
            st_nxt.rxs = RX_IDLE;
          end
        end
        RX_HOLD: begin
          if (rx_line) begin
            st_nxt.rxs = RX_IDLE;
          end
        end
        default: begin
          st_nxt.rxs = RX_IDLE;
        end
      endcase
    end

    // receive queue; in non-fifo mode it holds a single character
    if (rx_pop) begin
      st_nxt.rx_rd     = st_r.rx_rd + AW'(1);
      st_nxt.head_seen = 1'b0;
      st_nxt.dmard     = head.data;
    end
    if (rx_push && (st_r.rx_cnt - CW'(rx_pop)) < cap) begin
      st_nxt.rxm[st_r.rx_wr] = new_entry;
      st_nxt.rx_wr           = st_r.rx_wr + AW'(1);
    end
    st_nxt.rx_cnt = st_r.rx_cnt - CW'(rx_pop)
                    + CW'(rx_push && (st_r.rx_cnt - CW'(rx_pop)) < cap);

    // errors show once their character reaches the head
    if (lsr_read) begin
      st_nxt.oe  = 1'b0;
      st_nxt.pe  = 1'b0;
      st_nxt.fe  = 1'b0;
      st_nxt.line_break_flag = 1'b0;
    end
    if (rx_push && (st_r.rx_cnt - CW'(rx_pop)) >= cap) begin
      st_nxt.oe = 1'b1;
    end
    if (st_r.rx_cnt != '0 && !st_r.head_seen && !rx_pop) begin
      st_nxt.head_seen = 1'b1;
      st_nxt.pe        = st_nxt.pe | head.pe;
      st_nxt.fe        = st_nxt.fe | head.fe;
      st_nxt.line_break_flag       = st_nxt.line_break_flag | head.line_break_flag;
    end

    // transmit queue
    if (tx_push) begin
      st_nxt.txm[st_r.tx_wr] = tx_byte;
      st_nxt.tx_wr           = st_r.tx_wr + AW'(1);
    end
    if (tx_pop) begin
      st_nxt.tx_rd = st_r.tx_rd + AW'(1);
    end
    st_nxt.tx_cnt = st_r.tx_cnt + CW'(tx_push) - CW'(tx_pop);

    // modem deltas, set wins over clear
    st_nxt.prev = lvl;
    if (msr_read || (mode_change && !ir_msr_select)) begin
      st_nxt.delta = 4'h0;
    end
    st_nxt.delta[0] = st_nxt.delta[0] | (lvl.cts ^ st_r.prev.cts);
    st_nxt.delta[1] = st_nxt.delta[1] | (lvl.dsr ^ st_r.prev.dsr);
    st_nxt.delta[2] = st_nxt.delta[2] | (st_r.prev.ri & ~lvl.ri);
    st_nxt.delta[3] = st_nxt.delta[3] | (lvl.dcd ^ st_r.prev.dcd);

    // register writes; line status has no write path
    if (reg_wr && reg_addr == `SIS_OFF_MODE_CTRL) begin
      st_nxt.modem_mode_control_ext = reg_wdata & (extended_mode ? `SIS_MCR_EXT_MASK : `SIS_MCR_NONEXT_MASK);
    end else if (reg_wr && reg_addr == `SIS_OFF_SCRATCH && !extended_mode) begin
      st_nxt.scratch_byte = reg_wdata;
    end

    // read data, valid in the following cycle
    if (reg_addr == `SIS_OFF_DATA) begin
      st_nxt.rdata = (st_r.rx_cnt != '0) ? head.data : 8'h00;
    end else if (reg_addr == `SIS_OFF_MODE_CTRL) begin
      st_nxt.rdata = st_r.modem_mode_control_ext;
    end else if (reg_addr == `SIS_OFF_LINE_STAT) begin
      st_nxt.rdata = lsr_val;
    end else if (reg_addr == `SIS_OFF_MODEM_STAT) begin
      st_nxt.rdata = msr_val;
    end else if (reg_addr == `SIS_OFF_SCRATCH && !extended_mode) begin
      st_nxt.rdata = st_r.scratch_byte;
    end else begin
      st_nxt.rdata = 8'h00;
    end

    // flushes: mode change empties both queues and pending status
    if (mode_change || rx_soft_reset) begin
      st_nxt.rx_rd     = '0;
      st_nxt.rx_wr     = '0;
      st_nxt.rx_cnt    = '0;
      st_nxt.head_seen = 1'b0;
      st_nxt.oe        = 1'b0;
      st_nxt.pe        = 1'b0;
      st_nxt.fe        = 1'b0;
      st_nxt.line_break_flag       = 1'b0;
    end
    if (mode_change || tx_soft_reset) begin
      st_nxt.tx_rd  = '0;
      st_nxt.tx_wr  = '0;
      st_nxt.tx_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.modem_mode_control_ext  <= `SIS_MCR_RESET;
      st_r.scratch_byte  <= `SIS_SPR_RESET;
      st_r.rxs  <= RX_IDLE;
      st_r.prev <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata            = st_r.rdata;
  assign dma_rdata            = st_r.dmard;
  assign dma_enable           = st_r.modem_mode_control_ext[`SIS_MCR_DMA_EN];
  assign transmit_deferral    = st_r.modem_mode_control_ext[`SIS_MCR_TRANSMIT_DEFERRAL] & fifo_enable;
  assign tx_data              = st_r.txm[st_r.tx_rd];
  assign tx_avail             = (st_r.tx_cnt != '0);
  assign dtr_n                = ~st_r.modem_mode_control_ext[`SIS_MCR_DTR];
  assign rts_n                = ~st_r.modem_mode_control_ext[`SIS_MCR_RTS];
  assign operating_mode_field = mode;
  assign aux_status_clear     = st_r.aux_clr;
  assign line_status_irq      = line_irq_enable & (st_r.oe | st_r.pe | st_r.fe | st_r.line_break_flag);
  assign modem_status_event   = modem_status_irq_enable & (st_r.delta != 4'h0);

endmodule // serial_ir_status_mode_control

//--- pkg/serial_ir_status_map.svh
// register offsets, field positions, reset values and mode codes of the status and mode-control block
// assumes a 3-bit register address with one byte per offset
`ifndef SERIAL_IR_STATUS_MAP_SVH
`define SERIAL_IR_STATUS_MAP_SVH

`define SIS_OFF_DATA        3'h0
`define SIS_OFF_MODE_CTRL   3'h4
`define SIS_OFF_LINE_STAT   3'h5
`define SIS_OFF_MODEM_STAT  3'h6
`define SIS_OFF_SCRATCH     3'h7

`define SIS_MCR_DTR         0
`define SIS_MCR_RTS         1
`define SIS_MCR_DMA_EN      2
`define SIS_MCR_TRANSMIT_DEFERRAL      3
`define SIS_MCR_LOOP        4
`define SIS_MCR_MODE_LO     5
`define SIS_MCR_MODE_HI     7
`define SIS_MCR_EXT_MASK    8'hEF
`define SIS_MCR_NONEXT_MASK 8'h1F
`define SIS_MCR_RESET       8'h00

`define SIS_LSR_RESET       8'h60
`define SIS_MSR_IR_FIXED    8'h30
`define SIS_SPR_RESET       8'h00

`define SIS_MODE_UART       3'h0
`define SIS_MODE_ASK_IR     3'h2
`define SIS_MODE_SIR        3'h3
`define SIS_MODE_CONSUMER   3'h6

`endif

//--- pkg/serial_ir_status_pkg.sv
// types shared by the status and mode-control block
// assumes the map header supplies all numeric constants
package serial_ir_status_pkg;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'h01,
    RX_DATA   = 5'h02,
    RX_PARITY = 5'h04,
    RX_STOP   = 5'h08,
    RX_HOLD   = 5'h10
  } rx_state_e;

  // one received character with the errors that travel with it
  typedef struct packed {
    logic       line_break_flag;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } rx_entry_s;

  // active-high modem status levels, ordered as status bits 7..4
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_lines_s;

endpackage

//--- verification/serial_ir_status_monitor.sv
// checker for the status and mode-control block, bound to its top ports
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module serial_ir_status_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       extended_mode,
  input wire logic       fifo_enable,
  input wire logic       ir_msr_select,
  input wire logic       line_irq_enable,
  input wire logic       modem_status_irq_enable,
  input wire logic       tx_avail,
  input wire logic       tx_shifter_busy,
  input wire logic       dma_enable,
  input wire logic       transmit_deferral,
  input wire logic [2:0] operating_mode_field,
  input wire logic       aux_status_clear,
  input wire logic       line_status_irq,
  input wire logic       modem_status_event
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence mode_wr;
    reg_wr && reg_addr == 3'h4 && extended_mode;
  endsequence
  sequence mode_change;
    mode_wr ##0 (reg_wdata[7:5] != operating_mode_field);
  endsequence
  sequence scratch_echo;
    (reg_wr && reg_addr == 3'h7 && !extended_mode) ##2 (reg_rd && reg_addr == 3'h7 && !extended_mode);
  endsequence
  mode_select_a: assert property (mode_wr |=> operating_mode_field == $past(reg_wdata[7:5]))
    else $error("mode field does not follow the write");
  dma_bit_a: assert property (mode_wr |=> dma_enable == $past(reg_wdata[2]))
    else $error("dma enable does not follow the write");
  deferral_gate_a: assert property ((transmit_deferral |-> fifo_enable) and (mode_wr ##1 fifo_enable |-> transmit_deferral == $past(reg_wdata[3])))
    else $error("deferral active without transmit queue");
  aux_clear_a: assert property (mode_change |=> aux_status_clear)
    else $error("no aux clear after a mode change");
  aux_cause_a: assert property (aux_status_clear |-> $past(reg_wr && reg_addr == 3'h4))
    else $error("aux clear without a mode write");
  line_irq_a: assert property (line_status_irq |-> line_irq_enable)
    else $error("line interrupt while disabled");
  modem_event_a: assert property (modem_status_event |-> modem_status_irq_enable)
    else $error("modem event while disabled");
  ir_fixed_a: assert property (reg_rd && reg_addr == 3'h6 && extended_mode && ir_msr_select
    && operating_mode_field inside {3'h2, 3'h3, 3'h6} |=> reg_rdata == 8'h30)
    else $error("infrared modem status not fixed");
  scratch_keep_a: assert property (scratch_echo |=> reg_rdata == $past(reg_wdata, 3))
    else $error("scratch byte not returned");
  tx_flags_a: assert property (reg_rd && reg_addr == 3'h5
    |=> reg_rdata[6:5] == $past({!tx_avail && !tx_shifter_busy, !tx_avail}))
    else $error("transmit flags wrong");
endmodule // serial_ir_status_monitor

bind serial_ir_status_mode_control serial_ir_status_monitor mon_u (.*);

//--- verification/serial_line_partner.sv
// serial-side partner: bit tick, receive line, modem pins and transmit front end
// assumes send is called right after a rising clock edge
`timescale 1ns/1ps
module serial_line_partner (
  input  wire logic       clk,
  input  wire logic       tx_avail,
  output logic            bit_tick,
  output logic            rx_line,
  output logic            tx_take,
  output logic            tx_shifter_busy,
  output logic      [3:0] modem_n
);
  logic [1:0] div_r = 2'h0;
  int         busy_r = 0;
  logic       stall = 1'b0;
  initial begin
    rx_line = 1'b1;
    modem_n = 4'hF;
    tx_take = 1'b0;
  end
  assign bit_tick = div_r == 2'h3;
  assign tx_shifter_busy = busy_r > 0;
  // front end takes one byte, then shifts for 8 cycles
  always @(posedge clk) begin
    div_r <= div_r + 2'h1;
    tx_take <= 1'b0;
    if (busy_r > 0) busy_r <= busy_r - 1;
    else if (tx_avail && !stall && !tx_take) begin
      tx_take <= 1'b1;
      busy_r <= 8;
    end
  end
  // bits go out lsb first, each held from one tick to the next
  task automatic send(input logic [21:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk iff bit_tick);
      rx_line <= b[i];
    end
    @(posedge clk iff bit_tick);
    rx_line <= 1'b1;
    @(posedge clk);
  endtask
endmodule // serial_line_partner

//--- verification/tb_serial_ir_status_mode_control.sv
// self-checking bench for the status and mode-control block
// assumes the partner model supplies ticks, line, modem pins and front end
`timescale 1ns/1ps
module tb_serial_ir_status_mode_control;
  import serial_ir_status_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [2:0] reg_addr = '0, operating_mode_field;
  logic [7:0] reg_wdata = '0, dma_wdata = '0, reg_rdata, dma_rdata, tx_data, v, w;
  logic extended_mode = 0, fifo_enable = 0, loop_ext = 0, ir_msr_select = 0;
  logic parity_enable = 0, parity_even = 0, line_irq_enable = 0, modem_status_irq_enable = 0;
  logic rx_soft_reset = 0, tx_soft_reset = 0, dma_rd = 0, dma_wr = 0;
  logic rx_line, bit_tick, tx_take, tx_shifter_busy, cts_n, dsr_n, ri_n, dcd_n;
  logic dma_enable, tx_avail, transmit_deferral, dtr_n, rts_n, aux_status_clear;
  logic line_status_irq, modem_status_event;
  logic [3:0] modem_n;
  logic [15:0] q[$];
  logic [2:0] codes[4] = '{3'h0, 3'h2, 3'h3, 3'h6};
  int error_cnt = 0, n_tests = 0, seed = 46;
  assign {dcd_n, ri_n, dsr_n, cts_n} = modem_n;
  serial_ir_status_mode_control dut_u (.*);
  serial_line_partner pu (.clk(clk), .tx_avail(tx_avail), .bit_tick(bit_tick), .rx_line(rx_line),
    .tx_take(tx_take), .tx_shifter_busy(tx_shifter_busy), .modem_n(modem_n));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // read noting the expected byte and the mask of bits that matter
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({e & m, m});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [10:0] fr(input logic [7:0] d, input logic p, input logic s);
    return {s, p, d, 1'b0};
  endfunction
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) begin
      chk(reg_rdata & q[0][7:0], q[0][15:8]);
      void'(q.pop_front());
    end
  end
  initial begin
    #300us;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(3'h5, 8'h60, 8'hFF);
    rd(3'h4, 8'h00, 8'hFF);
    rd(3'h6, 8'h00, 8'hFF);
    rd(3'h1, 8'h00, 8'hFF);
    wr(3'h5, 8'h00);
    rd(3'h5, 8'h60, 8'hFF);
    $display("reset values done");
    extended_mode <= 1'b1;
    fifo_enable <= 1'b1;
    foreach (codes[i]) begin
      v = {codes[i], 1'b0, 4'($random(seed))};
      wr(3'h4, v);
      rd(3'h4, v, 8'hFF);
      chk(8'(operating_mode_field), 8'(codes[i]));
      chk(8'(dma_enable), 8'(v[2]));
      chk(8'(transmit_deferral), 8'(v[3]));
    end
    wr(3'h4, 8'h08);
    chk(8'(transmit_deferral), 8'h01);
    fifo_enable <= 1'b0;
    @(posedge clk);
    chk(8'(transmit_deferral), 8'h00);
    $display("mode control done");
    fifo_enable <= 1'b1;
    parity_enable <= 1'b1;
    parity_even <= 1'b1;
    line_irq_enable <= 1'b1;
    wr(3'h4, 8'h04);
    v = 8'($random(seed)) | 8'h01;
    w = 8'($random(seed)) | 8'h02;
    pu.send({11'h7FF, fr(v, ^v, 1'b1)}, 11);
    rd(3'h5, 8'h01, 8'h9F);
    rd(3'h0, v, 8'hFF);
    rd(3'h5, 8'h00, 8'h01);
    pu.send({11'h7FF, fr(v, ~^v, 1'b1)}, 11);
    // the error reaches the flag on the edge at which send returns
    @(posedge clk);
    chk(8'(line_status_irq), 8'h01);
    rd(3'h5, 8'h85, 8'h8F);
    rd(3'h0, v, 8'hFF);
    rd(3'h5, 8'h00, 8'h8F);
    pu.send({fr(w, ^w, 1'b1), fr(v, ^v, 1'b0)}, 22);
    rd(3'h5, 8'h89, 8'h8F);
    rd(3'h0, v, 8'hFF);
    rd(3'h0, w, 8'hFF);
    pu.send(22'h0, 12);
    rd(3'h5, 8'h99, 8'h9F);
    dma_rd <= 1'b1;
    @(posedge clk);
    dma_rd <= 1'b0;
    @(negedge clk);
    chk(dma_rdata, 8'h00);
    @(posedge clk);
    rd(3'h5, 8'h00, 8'h01);
    fifo_enable <= 1'b0;
    pu.send({fr(w, ^w, 1'b1), fr(v, ^v, 1'b1)}, 22);
    rd(3'h5, 8'h03, 8'h03);
    rd(3'h0, v, 8'hFF);
    pu.send({11'h7FF, fr(w, ^w, 1'b1)}, 11);
    rx_soft_reset <= 1'b1;
    @(posedge clk);
    rx_soft_reset <= 1'b0;
    @(posedge clk);
    rd(3'h5, 8'h60, 8'hFF);
    $display("receive done");
    fifo_enable <= 1'b1;
    pu.stall = 1'b1;
    dma_wdata <= v;
    dma_wr <= 1'b1;
    @(posedge clk);
    dma_wr <= 1'b0;
    @(posedge clk);
    chk(8'(tx_avail), 8'h01);
    chk(tx_data, v);
    wr(3'h0, w);
    rd(3'h5, 8'h00, 8'h60);
    pu.stall = 1'b0;
    for (int i = 0; i < 200 && tx_avail; i++) @(posedge clk);
    rd(3'h5, 8'h20, 8'h60);
    for (int i = 0; i < 200 && tx_shifter_busy; i++) @(posedge clk);
    rd(3'h5, 8'h60, 8'h60);
    $display("transmit done");
    extended_mode <= 1'b0;
    wr(3'h4, 8'h1F);
    rd(3'h6, 8'hF0, 8'hF0);
    extended_mode <= 1'b1;
    loop_ext <= 1'b1;
    wr(3'h4, 8'h01);
    chk(8'({dtr_n, rts_n}), 8'h01);
    rd(3'h6, 8'h60, 8'hF0);
    loop_ext <= 1'b0;
    wr(3'h4, 8'h00);
    // leaving loopback drops dsr and ring: dsr delta and ring trailing edge
    rd(3'h6, 8'h06, 8'hFF);
    rd(3'h6, 8'h00, 8'hFF);
    modem_status_irq_enable <= 1'b1;
    pu.modem_n <= 4'hE;
    repeat (3) @(posedge clk);
    chk(8'(modem_status_event), 8'h01);
    rd(3'h6, 8'h11, 8'hFF);
    rd(3'h6, 8'h10, 8'hFF);
    pu.modem_n <= 4'hA;
    repeat (3) @(posedge clk);
    rd(3'h6, 8'h50, 8'hFF);
    pu.modem_n <= 4'hF;
    repeat (3) @(posedge clk);
    wr(3'h4, 8'h40);
    rd(3'h6, 8'h00, 8'h0F);
    ir_msr_select <= 1'b1;
    rd(3'h6, 8'h30, 8'hFF);
    $display("modem status done");
    extended_mode <= 1'b0;
    v = 8'($random(seed));
    wr(3'h7, v);
    rd(3'h7, v, 8'hFF);
    $display("scratch done");
    summarize();
  end
endmodule // tb_serial_ir_status_mode_control
